// >>> include/lsd_params.svh
// Register map, reset values and field positions of the line state detector
`ifndef LSD_PARAMS_SVH
`define LSD_PARAMS_SVH

// Register byte offsets on the Wishbone bus
`define LSD_ADR_CTRL 8'h00
`define LSD_ADR_VTHR 8'h04
`define LSD_ADR_ITHR 8'h08
`define LSD_ADR_VNOM 8'h0C
`define LSD_ADR_INOM 8'h10
`define LSD_ADR_STAT 8'h14

// Threshold settings, percent of rated value
`define LSD_VTHR_MIN 7'h0A
`define LSD_VTHR_MAX 7'h64
`define LSD_VTHR_RST 7'h3C
`define LSD_ITHR_MIN 7'h02
`define LSD_ITHR_MAX 7'h64
`define LSD_ITHR_RST 7'h0A
`define LSD_PCT_SCALE 7'h64

// Rated magnitude after reset
`define LSD_NOM_RST 16'h1000

// Field positions
`define LSD_CTRL_EN_BIT 0
`define LSD_ST_DEAD_BIT 0
`define LSD_ST_LIVE_BIT 1
`define LSD_ST_VPK_LSB 2
`define LSD_ST_IPK_LSB 5

// Channel counts
`define LSD_NPH 3
`define LSD_NCH 6

`endif

// >>> include/lsd_pkg.sv
// Types shared by the line state detector modules
package lsd_pkg;

	typedef logic [6:0] lsd_pct_t;

	typedef enum logic
	{
		LSD_OP_OFF = 1'h0,
		LSD_OP_ON = 1'h1
	} lsd_oper_t;

endpackage : lsd_pkg

// >>> hdl/lsd_pickup_cmp.sv
// Per-channel magnitude against threshold comparators, registered
`include "lsd_params.svh"

module lsd_pickup_cmp
	import lsd_pkg::*;
#(
	parameter int MAG_W = 16
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Magnitudes: channels 0..2 voltages, 3..5 currents
	input wire logic [6*MAG_W-1:0] mag_i,
	// Settings
	input wire lsd_pct_t vthr_i,
	input wire lsd_pct_t ithr_i,
	input wire logic [MAG_W-1:0] vnom_i,
	input wire logic [MAG_W-1:0] inom_i,
	// Comparison results
	output logic [5:0] above_o,
	output logic [5:0] below_o
);

	// The reference checks below work in 32 bits
	generate
		if (MAG_W < 1 || MAG_W > 24)
		begin : g_bad_width
			$error("MAG_W must lie between 1 and 24");
		end
	endgenerate

	localparam int PRD_W = MAG_W + 7;

	typedef struct packed
	{
		logic [5:0] above;
		logic [5:0] below;
	} lsd_cmp_st_t;

	lsd_cmp_st_t st_r;
	lsd_cmp_st_t st_nxt;
	logic [5:0] above_c;
	logic [5:0] below_c;

	// Cross-multiplied so no divider is needed: mag*100 vs thr*rated
	genvar g;
	generate
		for (g = 0; g < `LSD_NCH; g++)
		begin : g_ch
			logic [PRD_W-1:0] lhs;
			logic [PRD_W-1:0] rhs;
			assign lhs = PRD_W'(mag_i[g*MAG_W +: MAG_W])
				* PRD_W'(`LSD_PCT_SCALE);
			if (g < `LSD_NPH)
			begin : g_v
				assign rhs = PRD_W'(vthr_i) * PRD_W'(vnom_i);
			end
			else
			begin : g_i
				assign rhs = PRD_W'(ithr_i) * PRD_W'(inom_i);
			end
			assign above_c[g] = lhs > rhs;
			assign below_c[g] = lhs < rhs;
		end
	endgenerate

	always_comb
	begin
		st_nxt.above = above_c;
		st_nxt.below = below_c;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign above_o = st_r.above;
	assign below_o = st_r.below;

	chk_cmp_exclusive: assert property (
		@(posedge clk_i) disable iff (rst_i)
		(above_o & below_o) == 6'h00)
	else $error("channel both above and below threshold");

	chk_cmp_phase1: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> above_o[0] ==
		($past(32'(mag_i[MAG_W-1:0]) * 32'(`LSD_PCT_SCALE))
		> $past(32'(vthr_i) * 32'(vnom_i))))
	else $error("phase 1 voltage comparison wrong");

	chk_cmp_current3: assert property (
		@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> below_o[5] ==
		($past(32'(mag_i[6*MAG_W-1 -: MAG_W]) * 32'(`LSD_PCT_SCALE))
		< $past(32'(ithr_i) * 32'(inom_i))))
	else $error("phase 3 current comparison wrong");

endmodule : lsd_pickup_cmp

// >>> hdl/lsd_decide.sv
// Decision stage: gates pickups and forms dead and live conditions
module lsd_decide
	import lsd_pkg::*;
(
	// Comparison results
	input wire logic [5:0] above_i,
	input wire logic [5:0] below_i,
	// Gating
	input wire lsd_oper_t oper_i,
	input wire logic block_i,
	// Decisions
	output logic dead_o,
	output logic live_o,
	output logic [2:0] vpk_o,
	output logic [2:0] ipk_o
);

	logic run;

	always_comb
	begin
		run = (oper_i == LSD_OP_ON) && !block_i;
		dead_o = run && (&below_i);
		live_o = run && (&above_i[2:0]);
		vpk_o = run ? above_i[2:0] : 3'h0;
		ipk_o = run ? above_i[5:3] : 3'h0;
	end

endmodule : lsd_decide

// >>> hdl/lsd_line_state_detector.sv
// Line state detector top: Wishbone settings, pickups and decision
//
// Contract
// - Dead line only while all voltages and all currents are below threshold.
// - Live line only while all three voltages exceed threshold; currents ignored.
// - Off/On enable setting gates the function; Off after reset.
// - Voltage threshold percent, 10 to 100 in steps of 1, reset 60.
// - Current threshold percent, 2 to 100 in steps of 1, reset 10.
// - Block input disables the function while asserted.
// - Per phase voltage pickup high while voltage exceeds its threshold.
// - Per phase current pickup high while current exceeds its threshold.
// - Decision combines six pickups with enable and block input.
// - Dead line is a separate binary status output for other logic.
`include "lsd_params.svh"

module lsd_line_state_detector
	import lsd_pkg::*;
#(
	parameter int MAG_W = 16
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Fundamental magnitudes from the Fourier stage
	input wire logic [MAG_W-1:0] phase1_voltage_fundamental_i,
	input wire logic [MAG_W-1:0] phase2_voltage_fundamental_i,
	input wire logic [MAG_W-1:0] phase3_voltage_fundamental_i,
	input wire logic [MAG_W-1:0] phase1_current_fundamental_i,
	input wire logic [MAG_W-1:0] phase2_current_fundamental_i,
	input wire logic [MAG_W-1:0] phase3_current_fundamental_i,
	// Block from user logic
	input wire logic block_i,
	// Line state
	output logic dead_line_output_o,
	output logic live_line_output_o,
	// Per phase pickups
	output logic phase1_voltage_pickup_o,
	output logic phase2_voltage_pickup_o,
	output logic phase3_voltage_pickup_o,
	output logic phase1_current_pickup_o,
	output logic phase2_current_pickup_o,
	output logic phase3_current_pickup_o
);

	generate
		// Narrower fields would lose the rated magnitude after reset
		if (MAG_W < 13 || MAG_W > 16)
		begin : g_bad_width
			$error("MAG_W must lie between 13 and 16");
		end
	endgenerate

	typedef struct packed
	{
		logic ack;
		logic [31:0] dat;
		lsd_oper_t oper;
		lsd_pct_t vthr;
		lsd_pct_t ithr;
		logic [MAG_W-1:0] vnom;
		logic [MAG_W-1:0] inom;
		logic dead;
		logic live;
		logic [2:0] vpk;
		logic [2:0] ipk;
	} lsd_top_st_t;

	lsd_top_st_t st_r;
	lsd_top_st_t st_nxt;

	logic [6*MAG_W-1:0] mag_all;
	logic [5:0] pk_above;
	logic [5:0] pk_below;
	logic dec_dead;
	logic dec_live;
	logic [2:0] dec_vpk;
	logic [2:0] dec_ipk;
	logic bus_req;
	logic bus_wr;
	logic [15:0] wr_half;
	lsd_pct_t wr_pct;
	logic [31:0] rd_word;

	assign mag_all = {phase3_current_fundamental_i,
		phase2_current_fundamental_i,
		phase1_current_fundamental_i,
		phase3_voltage_fundamental_i,
		phase2_voltage_fundamental_i,
		phase1_voltage_fundamental_i};

	lsd_pickup_cmp #(
		.MAG_W(MAG_W)
	) u_cmp (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.mag_i(mag_all),
		.vthr_i(st_r.vthr),
		.ithr_i(st_r.ithr),
		.vnom_i(st_r.vnom),
		.inom_i(st_r.inom),
		.above_o(pk_above),
		.below_o(pk_below)
	);

	lsd_decide u_dec (
		.above_i(pk_above),
		.below_i(pk_below),
		.oper_i(st_r.oper),
		.block_i(block_i),
		.dead_o(dec_dead),
		.live_o(dec_live),
		.vpk_o(dec_vpk),
		.ipk_o(dec_ipk)
	);

	// Read mux; unmapped words read as zero
	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (wb_adr_i)
			`LSD_ADR_CTRL:
				rd_word[`LSD_CTRL_EN_BIT] = st_r.oper;
			`LSD_ADR_VTHR:
				rd_word[6:0] = st_r.vthr;
			`LSD_ADR_ITHR:
				rd_word[6:0] = st_r.ithr;
			`LSD_ADR_VNOM:
				rd_word[MAG_W-1:0] = st_r.vnom;
			`LSD_ADR_INOM:
				rd_word[MAG_W-1:0] = st_r.inom;
			`LSD_ADR_STAT:
			begin
				rd_word[`LSD_ST_DEAD_BIT] = st_r.dead;
				rd_word[`LSD_ST_LIVE_BIT] = st_r.live;
				rd_word[`LSD_ST_VPK_LSB +: 3] = st_r.vpk;
				rd_word[`LSD_ST_IPK_LSB +: 3] = st_r.ipk;
			end
			default:
				rd_word = 32'h0000_0000;
		endcase
	end

	always_comb
	begin
		st_nxt = st_r;
		// Ack one cycle after the request; the held request is not re-taken
		bus_req = wb_cyc_i && wb_stb_i && !st_r.ack;
		bus_wr = bus_req && wb_we_i;
		st_nxt.ack = bus_req;
		st_nxt.dat = bus_req ? rd_word : 32'h0000_0000;
		// Lanes 0 and 1 carry all settings; upper lanes are ignored
		wr_half[7:0] = wb_dat_i[7:0];
		wr_half[15:8] = wb_dat_i[15:8];
		wr_pct = wb_dat_i[6:0];
		if (bus_wr && wb_sel_i[0])
		begin
			case (wb_adr_i)
				`LSD_ADR_CTRL:
					st_nxt.oper = lsd_oper_t'(wb_dat_i[`LSD_CTRL_EN_BIT]);
				// Out of range thresholds are refused, the old value stays
				`LSD_ADR_VTHR:
					if (wr_pct >= `LSD_VTHR_MIN && wr_pct <= `LSD_VTHR_MAX)
						st_nxt.vthr = wr_pct;
				`LSD_ADR_ITHR:
					if (wr_pct >= `LSD_ITHR_MIN && wr_pct <= `LSD_ITHR_MAX)
						st_nxt.ithr = wr_pct;
				`LSD_ADR_VNOM:
					st_nxt.vnom[7:0] = wr_half[7:0];
				`LSD_ADR_INOM:
					st_nxt.inom[7:0] = wr_half[7:0];
				default:
					st_nxt.oper = st_r.oper;
			endcase
		end
		if (bus_wr && wb_sel_i[1])
		begin
			case (wb_adr_i)
				`LSD_ADR_VNOM:
					st_nxt.vnom[MAG_W-1:8] = wr_half[MAG_W-1:8];
				`LSD_ADR_INOM:
					st_nxt.inom[MAG_W-1:8] = wr_half[MAG_W-1:8];
				default:
					st_nxt.vnom = st_r.vnom;
			endcase
		end
		// Final register stage keeps every status output glitch free
		st_nxt.dead = dec_dead;
		st_nxt.live = dec_live;
		st_nxt.vpk = dec_vpk;
		st_nxt.ipk = dec_ipk;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_r.ack <= 1'h0;
			st_r.dat <= 32'h0000_0000;
			st_r.oper <= LSD_OP_OFF;
			st_r.vthr <= `LSD_VTHR_RST;
			st_r.ithr <= `LSD_ITHR_RST;
			st_r.vnom <= MAG_W'(`LSD_NOM_RST);
			st_r.inom <= MAG_W'(`LSD_NOM_RST);
			st_r.dead <= 1'h0;
			st_r.live <= 1'h0;
			st_r.vpk <= 3'h0;
			st_r.ipk <= 3'h0;
		end
		else
			st_r <= st_nxt;
	end

	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.dat;
	assign dead_line_output_o = st_r.dead;
	assign live_line_output_o = st_r.live;
	assign phase1_voltage_pickup_o = st_r.vpk[0];
	assign phase2_voltage_pickup_o = st_r.vpk[1];
	assign phase3_voltage_pickup_o = st_r.vpk[2];
	assign phase1_current_pickup_o = st_r.ipk[0];
	assign phase2_current_pickup_o = st_r.ipk[1];
	assign phase3_current_pickup_o = st_r.ipk[2];

	default clocking cb_main @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	chk_dead_all_low: assert property (
		dead_line_output_o == $past(st_r.oper == LSD_OP_ON && !block_i
		&& pk_below == 6'h3F))
	else $error("dead line output does not follow all-below condition");

	chk_live_volts_only: assert property (
		live_line_output_o == $past(st_r.oper == LSD_OP_ON && !block_i
		&& pk_above[2:0] == 3'h7))
	else $error("live line output does not follow voltage pickups");

	chk_dead_live_excl: assert property (
		!(dead_line_output_o && live_line_output_o))
	else $error("dead and live line asserted together");

	chk_reset_defaults: assert property (disable iff (1'b0)
		rst_i |=> st_r.oper == LSD_OP_OFF
		&& st_r.vthr == `LSD_VTHR_RST && st_r.ithr == `LSD_ITHR_RST
		&& st_r.vnom == MAG_W'(`LSD_NOM_RST))
	else $error("settings not at reset values after reset");

	chk_vthr_range: assert property (
		st_r.vthr >= `LSD_VTHR_MIN && st_r.vthr <= `LSD_VTHR_MAX)
	else $error("voltage threshold out of range");

	chk_ithr_range: assert property (
		st_r.ithr >= `LSD_ITHR_MIN && st_r.ithr <= `LSD_ITHR_MAX)
	else $error("current threshold out of range");

	chk_block_quiet: assert property (
		block_i ##1 block_i |=> !dead_line_output_o && !live_line_output_o
		&& st_r.vpk == 3'h0 && st_r.ipk == 3'h0)
	else $error("outputs active while blocked");

	chk_vpick_follow: assert property (
		st_r.vpk == $past((st_r.oper == LSD_OP_ON && !block_i)
		? pk_above[2:0] : 3'h0))
	else $error("voltage pickups do not follow comparison");

	chk_ipick_follow: assert property (
		st_r.ipk == $past((st_r.oper == LSD_OP_ON && !block_i)
		? pk_above[5:3] : 3'h0))
	else $error("current pickups do not follow comparison");

	chk_off_quiet: assert property (
		(st_r.oper == LSD_OP_OFF) [*2] |-> !dead_line_output_o
		&& !live_line_output_o && st_r.vpk == 3'h0 && st_r.ipk == 3'h0)
	else $error("outputs active while function is off");

	chk_ack_single: assert property (
		wb_ack_o |=> !wb_ack_o)
	else $error("ack held longer than one cycle");

	chk_vthr_written: assert property (
		!$stable(st_r.vthr) && !$past(rst_i) |-> $past(wb_cyc_i && wb_stb_i
		&& wb_we_i && wb_sel_i[0] && !wb_ack_o
		&& wb_adr_i == `LSD_ADR_VTHR))
	else $error("voltage threshold changed without a write");

	chk_oper_written: assert property (
		!$stable(st_r.oper) && !$past(rst_i) |-> $past(wb_cyc_i && wb_stb_i
		&& wb_we_i && wb_sel_i[0] && !wb_ack_o
		&& wb_adr_i == `LSD_ADR_CTRL))
	else $error("enable setting changed without a write");

endmodule : lsd_line_state_detector

// >>> tb/lsd_fourier_model.sv
// Behavioural Fourier stage feeding six fundamental magnitudes
module lsd_fourier_model
#(
	parameter int MAG_W = 16
)
(
	// Clock
	input wire logic clk_i,
	// Requested magnitudes, hold stalls the update
	input wire logic [6*MAG_W-1:0] want_i,
	input wire logic hold_i,
	// Magnitudes to the detector
	output logic [6*MAG_W-1:0] mag_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// One new set per clock, like a filter output register
	always_ff @(posedge clk_i)
	begin
		if (!hold_i)
		begin
			mag_o <= want_i;
		end
	end
endmodule : lsd_fourier_model

// >>> tb/lsd_testbench.sv
// Self-checking bench for the line state detector
`include "lsd_params.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, ack;
	logic rst = 1, cyc = 0, stb = 0, we = 0, blk = 0;
	logic [3:0] sel = 4'hF;
	logic [7:0] adr = '0;
	logic [7:0] outs;
	logic [31:0] wdat = '0, rdat, dout;
	logic [95:0] want = '0, mag;
	int fails = 0, num_checks = 0, seed = 94;
	int vt = 60, it = 10, vn = 4096, en = 0, kv, ki;
	int m[6];
	int bv[7] = '{1, 2, 9, 10, 100, 101, 127};

	lsd_fourier_model #(.MAG_W(16)) fourier
	(
		.clk_i(clk),
		.want_i(want),
		.hold_i(1'b0),
		.mag_o(mag)
	);

	lsd_line_state_detector #(.MAG_W(16)) dut
	(
		.clk_i(clk),
		.rst_i(rst),
		.wb_cyc_i(cyc),
		.wb_stb_i(stb),
		.wb_we_i(we),
		.wb_adr_i(adr),
		.wb_sel_i(sel),
		.wb_dat_i(wdat),
		.wb_dat_o(dout),
		.wb_ack_o(ack),
		.phase1_voltage_fundamental_i(mag[15:0]),
		.phase2_voltage_fundamental_i(mag[31:16]),
		.phase3_voltage_fundamental_i(mag[47:32]),
		.phase1_current_fundamental_i(mag[63:48]),
		.phase2_current_fundamental_i(mag[79:64]),
		.phase3_current_fundamental_i(mag[95:80]),
		.block_i(blk),
		.dead_line_output_o(outs[0]),
		.live_line_output_o(outs[1]),
		.phase1_voltage_pickup_o(outs[2]),
		.phase2_voltage_pickup_o(outs[3]),
		.phase3_voltage_pickup_o(outs[4]),
		.phase1_current_pickup_o(outs[5]),
		.phase2_current_pickup_o(outs[6]),
		.phase3_current_pickup_o(outs[7])
	);

	initial
	begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end

	initial
	begin
		#200000;
		fails++;
		results();
	end

	task automatic results();
		$display("Checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : results

	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Classic cycle; ack is sampled at the edge, before its updates land
	task automatic wb(logic w, logic [7:0] a, logic [31:0] d,
		logic [3:0] s = 4'hF);
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		// Only the watchdog ends a wait for the answer
		do
		begin
			@(posedge clk);
		end
		while (ack !== 1'b1);
		rdat = dout;
		cyc <= 0;
		stb <= 0;
	endtask : wb

	task automatic rd(logic [7:0] a, logic [31:0] exp);
		wb(0, a, 0);
		chk("register", rdat, exp);
	endtask : rd

	// Reference decision from the percentages, with integers
	function automatic logic [7:0] model(int b);
		logic [7:0] s;
		int t, nom, lo;
		s = '0;
		lo = 1;
		for (int k = 0; k < 6; k++)
		begin
			t = k < 3 ? vt : it;
			nom = k < 3 ? vn : `LSD_NOM_RST;
			s[k + 2] = m[k] * 100 > t * nom;
			lo = lo & (m[k] * 100 < t * nom);
		end
		s[0] = lo[0];
		s[1] = &s[4:2];
		return (en != 0 && b == 0) ? s : 8'h00;
	endfunction : model

	// Outputs trail the magnitudes by the stage plus two edges
	task automatic step(int b);
		@(posedge clk);
		blk <= b[0];
		for (int k = 0; k < 6; k++)
			want[16*k+:16] <= 16'(m[k]);
		repeat (4) @(posedge clk);
		chk("outputs", outs, model(b));
		rd(`LSD_ADR_STAT, model(b));
	endtask : step

	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 0;
		rd(`LSD_ADR_CTRL, 0);
		rd(`LSD_ADR_VTHR, 60);
		rd(`LSD_ADR_ITHR, 10);
		rd(`LSD_ADR_INOM, 32'h1000);
		rd(8'h18, 0);
		m = '{8000, 8000, 8000, 0, 0, 0};
		step(0);
		foreach (bv[i])
		begin
			wb(1, `LSD_ADR_VTHR, bv[i]);
			if (bv[i] >= 10 && bv[i] <= 100)
				vt = bv[i];
			rd(`LSD_ADR_VTHR, vt);
			wb(1, `LSD_ADR_ITHR, bv[i]);
			if (bv[i] >= 2 && bv[i] <= 100)
				it = bv[i];
			rd(`LSD_ADR_ITHR, it);
		end
		// Byte lanes: rated values split over lanes 0 and 1
		wb(1, `LSD_ADR_VNOM, 32'h0000_3355, 4'h2);
		rd(`LSD_ADR_VNOM, 32'h3300);
		wb(1, `LSD_ADR_INOM, 32'h0000_2277, 4'h1);
		rd(`LSD_ADR_INOM, 32'h1077);
		wb(1, `LSD_ADR_INOM, 32'h1000, 4'h3);
		wb(1, `LSD_ADR_VNOM, 32'h0800);
		vn = 2048;
		rd(`LSD_ADR_VNOM, 32'h0800);
		wb(1, `LSD_ADR_CTRL, 1, 4'hE);
		rd(`LSD_ADR_CTRL, 0);
		wb(1, `LSD_ADR_CTRL, 1);
		en = 1;
		rd(`LSD_ADR_CTRL, 1);
		// Common scale per group so dead and live both occur
		repeat (60)
		begin
			vt = 10 + $unsigned($random(seed)) % 91;
			it = 2 + $unsigned($random(seed)) % 99;
			wb(1, `LSD_ADR_VTHR, vt);
			wb(1, `LSD_ADR_ITHR, it);
			kv = $unsigned($random(seed)) % 16;
			ki = $unsigned($random(seed)) % 16;
			for (int k = 0; k < 6; k++)
				m[k] = (k < 3 ? vt * vn * kv : it * 4096 * ki) / 800
					+ $unsigned($random(seed)) % 3;
			step(0);
		end
		m = '{8000, 8000, 8000, 0, 0, 0};
		step(1);
		step(0);
		// Mid-run reset while enabled: settings return, outputs fall
		@(posedge clk);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		en = 0;
		vt = 60;
		it = 10;
		vn = 4096;
		rd(`LSD_ADR_CTRL, 0);
		rd(`LSD_ADR_VTHR, vt);
		rd(`LSD_ADR_ITHR, it);
		rd(`LSD_ADR_VNOM, 32'h1000);
		step(0);
		wb(1, `LSD_ADR_CTRL, 0);
		en = 0;
		step(0);
		results();
	end
endmodule : testbench
